// ### cmd_cfg.svh
// constants of the clock mode demo sequencer
// assumes a 100 MHz pclk and the apb slave in cmd_sequencer
`ifndef CMD_CFG_SVH
`define CMD_CFG_SVH

// register byte offsets
`define CMD_OFS_CTRL 12'h000
`define CMD_OFS_STEP 12'h004
`define CMD_OFS_LAMP 12'h008
`define CMD_OFS_STAT 12'h00c
`define CMD_OFS_MASK 12'h010
`define CMD_OFS_RES 12'h014

// ctrl fields
`define CMD_CTRL_SW_EN 0
`define CMD_CTRL_RESET_VAL 32'h0000_0001

// status / mask bit positions
`define CMD_EV_SW 0
`define CMD_EV_TICK 1
`define CMD_EV_CAL 2
`define CMD_EV_DONE 3
`define CMD_EV_HALT 4

// sequence
`define CMD_LAST_STEP 6'd41
`define CMD_AUTONOMOUS_PERIPHERAL_STANDBY_RET_A 6'd19
`define CMD_AUTONOMOUS_PERIPHERAL_STANDBY_RET_B 6'd30

// window compare limits (10-bit result)
`define CMD_WIN_LOWER 10'd240
`define CMD_WIN_UPPER 10'd255

// clock rates and times
`define CMD_PCLK_HZ 100000000
`define CMD_TICK_NS 10000000
`define CMD_TICK_CYC (`CMD_TICK_NS / (1000000000 / `CMD_PCLK_HZ))
`define CMD_CAL_NS 500000000
`define CMD_CAL_CYC (`CMD_CAL_NS / (1000000000 / `CMD_PCLK_HZ))
`define CMD_CONV_CLKS 2816
`define CMD_FAST_OSC_HZ 32000000
`define CMD_MID_OSC_HZ 4000000
`define CMD_MAIN_XTAL_HZ 20000000
`define CMD_XTAL_WAIT_LOG2 18
`define CMD_PRIO_LEVEL 2'd3

`endif

// ### cmd_panel.sv
// push switch and analog source beside the sequencer
// assumes the bench calls its tasks; changes follow a rising pclk
module cmd_panel (
	input wire logic pclk,
	output logic switch_in,
	output logic [9:0] analog_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************
	// switch and level drivers
	// ****************************
	initial begin
		switch_in = 1'b0;
		analog_sample = 10'h100;
	end
	task press;
		@(posedge pclk);
		switch_in <= 1'b1;
	endtask
	task lift;
		@(posedge pclk);
		switch_in <= 1'b0;
	endtask
	task level(input logic [9:0] v);
		@(posedge pclk);
		analog_sample <= v;
	endtask
endmodule

// ### cmd_pkg.sv
// types of the clock mode demo sequencer
// assumes cmd_cfg.svh for all numeric constants
package cmd_pkg;

	// cpu clock source
	typedef enum logic [2:0] {
		CMD_CLK_FAST = 3'h0,
		CMD_CLK_MID = 3'h1,
		CMD_CLK_SLOW = 3'h2,
		CMD_CLK_XTAL = 3'h3,
		CMD_CLK_SUB = 3'h4
	} cmd_clk_e;

	// operating mode
	typedef enum logic [2:0] {
		CMD_MODE_RUN = 3'h0,
		CMD_MODE_HALT = 3'h1,
		CMD_MODE_AUTONOMOUS_PERIPHERAL_STANDBY = 3'h2,
		CMD_MODE_STOP = 3'h3,
		CMD_MODE_STOP_HI = 3'h4,
		CMD_MODE_DARK = 3'h5
	} cmd_mode_e;

	// one step of the chain
	typedef struct packed {
		cmd_clk_e clk;
		cmd_mode_e mode;
	} cmd_step_s;

	// five lamps
	typedef struct packed {
		logic lamp_running;
		logic lamp_cpu_clocked;
		logic lamp_clock_bit_a;
		logic lamp_clock_bit_b;
		logic lamp_clock_bit_c;
	} cmd_lamp_s;

	// apb answer
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cmd_apb_rsp_s;

	// all state of the sequencer
	typedef struct packed {
		logic [5:0] step;
		logic halted;
		logic sw_d;
		logic sw_en;
		logic [4:0] stat;
		logic [4:0] mask;
		logic [31:0] tick_cnt;
		logic [31:0] cal_cnt;
		logic [11:0] conv_cnt;
		logic conv_busy;
		logic [9:0] result;
		cmd_lamp_s lamp;
		logic irq;
		cmd_apb_rsp_s rsp;
	} cmd_state_s;

endpackage

// ### cmd_seq_monitor.sv
// port checker of the clock mode demo sequencer
// assumes bind into cmd_sequencer, lamps active high
module cmd_seq_monitor #(
	parameter int unsigned TICK_CYC = 50,
	parameter int unsigned CAL_CYC = 4000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic switch_in,
	input wire logic [9:0] analog_sample,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lamp_running,
	input wire logic lamp_cpu_clocked,
	input wire logic lamp_clock_bit_a,
	input wire logic lamp_clock_bit_b,
	input wire logic lamp_clock_bit_c,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] lamp_v;
	// ****************************
	// lamp and bus relations
	// ****************************
	assign lamp_v = {lamp_running, lamp_cpu_clocked, lamp_clock_bit_a, lamp_clock_bit_b,
		lamp_clock_bit_c};
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence sw_rise;
		!switch_in ##1 switch_in;
	endsequence
	sequence apb_setup;
		psel && !penable;
	endsequence
	AST_APB_ANSWER: assert property (apb_setup |=> pready)
		else $error("no answer after setup");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_RESET_LAMPS: assert property (disable iff (1'b0) !presetn ##1 !presetn |-> lamp_v == 5'h19 && !irq)
		else $error("wrong lamps in reset");
	AST_LEGAL_LAMPS: assert property (lamp_v inside {5'h19, 5'h09, 5'h11, 5'h01, 5'h03,
		5'h1a, 5'h0a, 5'h12, 5'h02, 5'h1b, 5'h0b, 5'h1d, 5'h0d, 5'h05, 5'h1e, 5'h0e, 5'h00})
		else $error("illegal lamp pattern");
	AST_CHANGE_CAUSE: assert property ($changed(lamp_v) |->
		$past(switch_in) != $past(switch_in, 2) || $past(lamp_v) inside {5'h11, 5'h12})
		else $error("lamps changed without cause");
	AST_AUTONOMOUS_PERIPHERAL_STANDBY_HOLDS: assert property (sw_rise ##0 lamp_v inside {5'h11, 5'h12} |=>
		$stable(lamp_v)) else $error("switch left autonomous_peripheral_standby");
	AST_DARK_STAYS: assert property (lamp_v == 5'h00 |=> lamp_v == 5'h00)
		else $error("dark halt left");
	AST_STOP_ENTRY: assert property ($changed(lamp_v) && lamp_v inside {5'h01, 5'h02, 5'h03,
		5'h05} |-> $past(lamp_v) == (lamp_v == 5'h02 ? 5'h1a : lamp_v == 5'h05 ? 5'h1d : 5'h19))
		else $error("stop entered from wrong pattern");
	AST_HALT_ENTRY: assert property ($changed(lamp_v) && lamp_v[4:3] == 2'b01 |->
		$past(lamp_v) == (lamp_v | 5'h10)) else $error("halt entered from wrong pattern");
endmodule

bind cmd_sequencer cmd_seq_monitor #(.TICK_CYC(TICK_CYC), .CAL_CYC(CAL_CYC))
	cmd_seq_monitor_inst (.*);

// ### cmd_sequencer.sv
// clock mode demo sequencer: 41-step clock/mode chain with lamp encoding
// assumes synchronous switch and 10-bit sample inputs, apb master on pclk
//
// Operation
// - switch rising edge advances the 41-step chain
// - steps 19 and 30 are entered on conversion done
// - after 41 falling edge darkens lamps, halts
// - fast oscillator lamp patterns per mode
// - high-speed stop shows distinct lamp pattern
// - middle oscillator lamp patterns per mode
// - slow oscillator: run and halt only
// - main crystal lamp patterns per mode
// - switch interrupt rising edge, enabled at init
// - interval tick every 10 ms
// - calendar periodic interrupt every 0.5 s
// - one-shot conversion started by calendar interrupt
// - done only inside window 240..255
// - conversion takes 2816 clock cycles
// - fast osc 32 MHz, middle osc 4 MHz
// - main crystal 20 MHz, 2^18 wait
// - all four interrupts at level 3; the code has no levels, all five status events drive the one irq
// - reset selects main clock, lamps outputs
//
// Our own choices: the APB register port and the placing of the registers.
`include "cmd_cfg.svh"

module cmd_sequencer #(
	parameter int unsigned TICK_CYC = `CMD_TICK_CYC,
	parameter int unsigned CAL_CYC = `CMD_CAL_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic switch_in,
	input wire logic [9:0] analog_sample,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic lamp_running,
	output logic lamp_cpu_clocked,
	output logic lamp_clock_bit_a,
	output logic lamp_clock_bit_b,
	output logic lamp_clock_bit_c,
	output logic irq
);

	// ****************************************
	// chain table
	// ****************************************

	// clock and mode shown after step n (0 = state after reset)
	function automatic cmd_pkg::cmd_step_s step_of(input logic [5:0] n);
		cmd_pkg::cmd_step_s s;
		s.clk = cmd_pkg::CMD_CLK_FAST;
		s.mode = cmd_pkg::CMD_MODE_RUN;
		case (n)
			6'd2, 6'd4, 6'd7, 6'd31: s.clk = cmd_pkg::CMD_CLK_SUB;
			6'd3: begin
				s.clk = cmd_pkg::CMD_CLK_SUB;
				s.mode = cmd_pkg::CMD_MODE_HALT;
			end
			6'd6, 6'd8, 6'd10, 6'd12, 6'd21, 6'd23: s.clk = cmd_pkg::CMD_CLK_XTAL;
			6'd9: begin
				s.clk = cmd_pkg::CMD_CLK_XTAL;
				s.mode = cmd_pkg::CMD_MODE_HALT;
			end
			6'd11: begin
				s.clk = cmd_pkg::CMD_CLK_XTAL;
				s.mode = cmd_pkg::CMD_MODE_STOP;
			end
			6'd14: s.mode = cmd_pkg::CMD_MODE_HALT;
			6'd16: s.mode = cmd_pkg::CMD_MODE_STOP;
			6'd18: s.mode = cmd_pkg::CMD_MODE_AUTONOMOUS_PERIPHERAL_STANDBY;
			6'd40: s.mode = cmd_pkg::CMD_MODE_STOP_HI;
			6'd20, 6'd24, 6'd26, 6'd28, 6'd30, 6'd32, 6'd34: s.clk = cmd_pkg::CMD_CLK_MID;
			6'd25: begin
				s.clk = cmd_pkg::CMD_CLK_MID;
				s.mode = cmd_pkg::CMD_MODE_HALT;
			end
			6'd27: begin
				s.clk = cmd_pkg::CMD_CLK_MID;
				s.mode = cmd_pkg::CMD_MODE_STOP;
			end
			6'd29: begin
				s.clk = cmd_pkg::CMD_CLK_MID;
				s.mode = cmd_pkg::CMD_MODE_AUTONOMOUS_PERIPHERAL_STANDBY;
			end
			6'd22, 6'd33, 6'd36, 6'd38: s.clk = cmd_pkg::CMD_CLK_SLOW;
			6'd37: begin
				s.clk = cmd_pkg::CMD_CLK_SLOW;
				s.mode = cmd_pkg::CMD_MODE_HALT;
			end
			default: begin
			end
		endcase
		return s;
	endfunction

	// lamp pattern of a clock and mode
	function automatic cmd_pkg::cmd_lamp_s lamp_of(input cmd_pkg::cmd_step_s s);
		cmd_pkg::cmd_lamp_s l;
		logic [2:0] src;
		src = 3'h1;
		l = '0;
		// upper pair: running and cpu clocked per mode
		case (s.mode)
			cmd_pkg::CMD_MODE_RUN: begin
				l.lamp_running = 1'b1;
				l.lamp_cpu_clocked = 1'b1;
			end
			cmd_pkg::CMD_MODE_HALT: l.lamp_cpu_clocked = 1'b1;
			cmd_pkg::CMD_MODE_AUTONOMOUS_PERIPHERAL_STANDBY: l.lamp_running = 1'b1;
			default: begin
			end
		endcase
		case (s.clk)
			cmd_pkg::CMD_CLK_FAST: src = 3'h1;
			cmd_pkg::CMD_CLK_MID: src = 3'h2;
			cmd_pkg::CMD_CLK_SLOW: src = 3'h3;
			cmd_pkg::CMD_CLK_XTAL: src = 3'h5;
			cmd_pkg::CMD_CLK_SUB: src = 3'h6;
			default: src = 3'h1;
		endcase
		// high-speed stop forces clock bits b and c, clears a
		if (s.mode == cmd_pkg::CMD_MODE_STOP_HI) begin
			src = 3'h3;
		end
		{l.lamp_clock_bit_a, l.lamp_clock_bit_b, l.lamp_clock_bit_c} = src;
		if (s.mode == cmd_pkg::CMD_MODE_DARK) begin
			l = '0;
		end
		return l;
	endfunction

	// ****************************************
	// next state
	// ****************************************

	cmd_pkg::cmd_state_s st_r;
	cmd_pkg::cmd_state_s st_nxt;
	logic wr_acc;
	logic rd_acc;
	logic sw_rise;
	logic sw_fall;
	logic tick_ev;
	logic cal_ev;
	logic done_ev;
	logic autonomous_peripheral_standby_wait;
	logic [4:0] ev;
	cmd_pkg::cmd_step_s cur;

	always_comb begin
		st_nxt = st_r;
		cur = step_of(st_r.step);
		wr_acc = psel && penable && pwrite && st_r.rsp.pready;
		rd_acc = psel && !penable && !pwrite;
		st_nxt.sw_d = switch_in;
		// rising edge detect, gated by enable
		sw_rise = st_r.sw_en && switch_in && !st_r.sw_d;
		sw_fall = st_r.sw_en && !switch_in && st_r.sw_d;
		tick_ev = (st_r.tick_cnt == TICK_CYC - 1);
		st_nxt.tick_cnt = tick_ev ? 32'h0 : st_r.tick_cnt + 32'h1;
		cal_ev = (st_r.cal_cnt == CAL_CYC - 1);
		st_nxt.cal_cnt = cal_ev ? 32'h0 : st_r.cal_cnt + 32'h1;
		done_ev = 1'b0;
		if (cal_ev && !st_r.conv_busy) begin
			st_nxt.conv_busy = 1'b1;
			st_nxt.conv_cnt = 12'h0;
			st_nxt.result = analog_sample;
		end else if (st_r.conv_busy) begin
			if (st_r.conv_cnt == 12'(`CMD_CONV_CLKS - 1)) begin
				st_nxt.conv_busy = 1'b0;
				done_ev = (st_r.result >= `CMD_WIN_LOWER) && (st_r.result <= `CMD_WIN_UPPER);
			end else begin
				st_nxt.conv_cnt = st_r.conv_cnt + 12'h1;
			end
		end
		// autonomous_peripheral_standby returns wait for conversion done
		autonomous_peripheral_standby_wait = (st_r.step == `CMD_AUTONOMOUS_PERIPHERAL_STANDBY_RET_A - 6'd1)
			|| (st_r.step == `CMD_AUTONOMOUS_PERIPHERAL_STANDBY_RET_B - 6'd1);
		if (!st_r.halted) begin
			if (autonomous_peripheral_standby_wait) begin
				if (done_ev) begin
					st_nxt.step = st_r.step + 6'd1;
				end
			end else if (st_r.step != `CMD_LAST_STEP) begin
				if (sw_rise) begin
					st_nxt.step = st_r.step + 6'd1;
				end
			// final falling edge halts until reset
			end else if (sw_fall) begin
				st_nxt.halted = 1'b1;
			end
		end
		if (st_nxt.halted) begin
			cur.mode = cmd_pkg::CMD_MODE_DARK;
			cur.clk = cmd_pkg::CMD_CLK_FAST;
		end else begin
			cur = step_of(st_nxt.step);
		end
		st_nxt.lamp = lamp_of(cur);
		// all events share one priority level
		ev = 5'h0;
		ev[`CMD_EV_SW] = sw_rise;
		ev[`CMD_EV_TICK] = tick_ev;
		ev[`CMD_EV_CAL] = cal_ev;
		ev[`CMD_EV_DONE] = done_ev;
		ev[`CMD_EV_HALT] = st_nxt.halted && !st_r.halted;
		// apb write, write one to clear status; set wins
		st_nxt.rsp.pready = psel && !penable;
		st_nxt.rsp.pslverr = 1'b0;
		if (wr_acc) begin
			case (paddr)
				`CMD_OFS_CTRL: st_nxt.sw_en = pwdata[`CMD_CTRL_SW_EN];
				`CMD_OFS_STAT: st_nxt.stat = st_r.stat & ~pwdata[4:0];
				`CMD_OFS_MASK: st_nxt.mask = pwdata[4:0];
				default: begin
				end
			endcase
		end
		st_nxt.stat = st_nxt.stat | ev;
		st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
		// apb read data captured in setup cycle
		if (psel && !penable) begin
			st_nxt.rsp.prdata = 32'h0;
			case (paddr)
				`CMD_OFS_CTRL: st_nxt.rsp.prdata = {31'h0, st_r.sw_en};
				`CMD_OFS_STEP: st_nxt.rsp.prdata = {25'h0, st_r.halted, st_r.step};
				`CMD_OFS_LAMP: st_nxt.rsp.prdata = {27'h0, st_r.lamp};
				`CMD_OFS_STAT: st_nxt.rsp.prdata = {27'h0, st_r.stat};
				`CMD_OFS_MASK: st_nxt.rsp.prdata = {27'h0, st_r.mask};
				`CMD_OFS_RES: st_nxt.rsp.prdata = {22'h0, st_r.result};
				default: st_nxt.rsp.pslverr = rd_acc || pwrite;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************

	// reset: main fast clock running, lamps driven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.sw_en <= 1'b1;
			st_r.lamp <= 5'h19;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flip-flops
	assign prdata = st_r.rsp.prdata;
	assign pready = st_r.rsp.pready;
	assign pslverr = st_r.rsp.pslverr;
	assign lamp_running = st_r.lamp.lamp_running;
	assign lamp_cpu_clocked = st_r.lamp.lamp_cpu_clocked;
	assign lamp_clock_bit_a = st_r.lamp.lamp_clock_bit_a;
	assign lamp_clock_bit_b = st_r.lamp.lamp_clock_bit_b;
	assign lamp_clock_bit_c = st_r.lamp.lamp_clock_bit_c;
	assign irq = st_r.irq;

endmodule

// ### cmd_sequencer_tb.sv
// self-checking bench of the clock mode demo sequencer
// assumes cmd_cfg.svh offsets and cmd_panel as the far side
`include "cmd_cfg.svh"
module cmd_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic switch_in, pready, pslverr, irq, perr;
	logic [9:0] analog_sample;
	logic [31:0] prdata, q;
	logic [4:0] lamp_v;
	int mismatches = 0;
	int checked = 0;
	logic [4:0] tbl [0:41] = '{5'h19, 5'h19, 5'h1e, 5'h0e, 5'h1e, 5'h19, 5'h1d, 5'h1e, 5'h1d,
		5'h0d, 5'h1d, 5'h05, 5'h1d, 5'h19, 5'h09, 5'h19, 5'h01, 5'h19, 5'h11, 5'h19, 5'h1a,
		5'h1d, 5'h1b, 5'h1d, 5'h1a, 5'h0a, 5'h1a, 5'h02, 5'h1a, 5'h12, 5'h1a, 5'h1e, 5'h1a,
		5'h1b, 5'h1a, 5'h19, 5'h1b, 5'h0b, 5'h1b, 5'h19, 5'h03, 5'h19};
	// ****************************
	// clock, design and far side
	// ****************************
	always #5 pclk = ~pclk;
	cmd_sequencer #(.TICK_CYC(50), .CAL_CYC(4000)) cmd_sequencer_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .switch_in(switch_in), .analog_sample(analog_sample), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lamp_running(lamp_v[4]),
		.lamp_cpu_clocked(lamp_v[3]), .lamp_clock_bit_a(lamp_v[2]),
		.lamp_clock_bit_b(lamp_v[1]), .lamp_clock_bit_c(lamp_v[0]), .irq(irq));
	cmd_panel cmd_panel_inst (.pclk(pclk), .switch_in(switch_in), .analog_sample(analog_sample));
	// compare and count
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) chk("pready", 32'h0, 32'h1);
	endtask
	// release, press, then expect step i
	task advance(input int i);
		cmd_panel_inst.lift();
		repeat (3) @(posedge pclk);
		cmd_panel_inst.press();
		repeat (3) @(posedge pclk);
		chk("lamp", lamp_v, tbl[i]);
		apb(1'b0, `CMD_OFS_STEP, 32'h0);
		chk("step", q, i);
	endtask
	// autonomous_peripheral_standby return only by a window hit
	task wake(input int i, input logic [9:0] hit, input logic [9:0] miss);
		int n;
		advance(i - 1);
		cmd_panel_inst.level(hit);
		for (n = 0; n < 1000 && q !== i; n++) begin
			repeat (10) @(posedge pclk);
			apb(1'b0, `CMD_OFS_STEP, 32'h0);
		end
		chk("wake step", q, i);
		chk("wake lamp", lamp_v, tbl[i]);
		apb(1'b0, `CMD_OFS_RES, 32'h0);
		chk("result", q, hit);
		cmd_panel_inst.level(miss);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#400000;
		mismatches++;
		complete_run();
	end
	// test sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CMD_OFS_CTRL, 32'h0);
		chk("ctrl", q, `CMD_CTRL_RESET_VAL);
		apb(1'b0, `CMD_OFS_LAMP, 32'h0);
		chk("lamp reg", q, 32'h19);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", {perr, q[30:0]}, 32'h8000_0000);
		apb(1'b1, `CMD_OFS_CTRL, 32'h0);
		advance(0);
		apb(1'b1, `CMD_OFS_CTRL, 32'h1);
		apb(1'b1, `CMD_OFS_MASK, 32'h1);
		$display("test registers done");
		for (int i = 1; i <= 41; i++) begin
			if (i == 19)
				wake(19, 10'd255, 10'd239);
			else if (i == 30)
				wake(30, 10'd240, 10'd256);
			else
				advance(i);
			if (i == 1) begin
				chk("irq raised", irq, 1'b1);
				apb(1'b1, `CMD_OFS_MASK, 32'h0);
				@(posedge pclk);
				chk("irq masked", irq, 1'b0);
				apb(1'b1, `CMD_OFS_MASK, 32'h1);
				apb(1'b1, `CMD_OFS_STAT, 32'h1);
				@(posedge pclk);
				chk("irq cleared", irq, 1'b0);
			end
		end
		$display("test chain done");
		apb(1'b0, `CMD_OFS_STAT, 32'h0);
		chk("tick", q[1], 1'b1);
		cmd_panel_inst.lift();
		repeat (3) @(posedge pclk);
		chk("dark", lamp_v, 5'h00);
		cmd_panel_inst.press();
		repeat (3) @(posedge pclk);
		chk("dark stays", lamp_v, 5'h00);
		apb(1'b0, `CMD_OFS_STEP, 32'h0);
		chk("halted step", q, 32'h69);
		cmd_panel_inst.lift();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("reset lamp", lamp_v, tbl[0]);
		apb(1'b0, `CMD_OFS_STEP, 32'h0);
		chk("reset step", q, 32'h0);
		$display("test halt done");
		complete_run();
	end
endmodule
